// [logic/scem_pkg.sv]
/*
 * Package for the synchronous character channel event, mask and status
 * block: register offsets, event bit positions, reset values, commands.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
package scem_pkg;

    localparam logic [7:0]  ADDR_EVENT      = 8'h00;
    localparam logic [7:0]  ADDR_MASK       = 8'h04;
    localparam logic [7:0]  ADDR_STATUS     = 8'h08;
    localparam logic [7:0]  ADDR_COMMAND    = 8'h0C;
    localparam logic [7:0]  ADDR_MODE       = 8'h10;
    localparam logic [7:0]  ADDR_DESC_BASE  = 8'h14;
    localparam logic [7:0]  ADDR_DESC_PTR   = 8'h18;
    localparam logic [7:0]  ADDR_RX_INFO    = 8'h1C;

    // Event bit positions
    localparam int          EVT_RX          = 0;
    localparam int          EVT_TX          = 1;
    localparam int          EVT_BSY         = 2;
    localparam int          EVT_RCH         = 3;
    localparam int          EVT_TXE         = 4;
    localparam int          EVT_GRA         = 7;
    localparam int          EVT_DCC         = 10;
    localparam logic [15:0] EVT_IMPL_MASK   = 16'h049F;

    localparam logic [15:0] EVENT_RESET     = 16'h0000;
    localparam logic [15:0] MASK_RESET      = 16'h0000;
    // Status bits 5..2 read as one
    localparam logic [7:0]  STATUS_FIXED    = 8'h3C;
    localparam int          STATUS_CS_BIT   = 1;

    // Command codes in write data bits 3:0
    localparam logic [3:0]  CMD_INIT_PARAMS = 4'h0;
    localparam logic [3:0]  CMD_GRACEFUL    = 4'h1;
    localparam logic [3:0]  CMD_HUNT        = 4'h2;
    localparam logic [3:0]  CMD_RESET_BCS   = 4'h3;

    // Mode register bits
    localparam int          MODE_TRANSP     = 0;
    localparam int          MODE_TX_EN      = 1;
    localparam int          MODE_RX_EN      = 2;

    localparam logic [15:0] MAX_RX_LEN_DEF  = 16'h0010;

    typedef enum logic [1:0]
    {
        RX_HUNT  = 2'b00,
        RX_DATA  = 2'b01,
        RX_ESC   = 2'b10,
        RX_BUSY  = 2'b11
    } scem_rx_state_t;

endpackage

// [logic/scem_edge_flag.sv]
/*
 * One sticky event flag: hardware set, write-one clear, set wins.
 * Assumes pclk domain with asynchronous active-low reset.
 */
module scem_edge_flag
    import scem_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set_evt,
    input  wire logic clr_evt,
    output logic      flag
);

    logic flag_reg;
    logic flag_next;

    always_comb
    begin
        flag_next = flag_reg;
        if (clr_evt)
        begin
            flag_next = 1'b0;
        end
        if (set_evt)
        begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule

// [logic/scem_top.sv]
/*
 * Event, mask and line-status registers of a synchronous character
 * channel with receive control: check accumulation, escape stripping,
 * end-of-block detection, buffer closing and busy condition.
 * Assumes characters, events and carrier sense arrive synchronous to pclk.
 */
module scem_top
    import scem_pkg::*;
#(
    parameter int          MAX_RX_LEN = 16,
    parameter logic [7:0]  SYNC_CHAR  = 8'h33,
    parameter logic [7:0]  ESC_CHAR   = 8'h55,
    parameter logic [7:0]  ENQ_CHAR   = 8'h2D
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dpll_cs,
    input  wire logic        tx_msg_active,
    input  wire logic        tx_cts_lost,
    input  wire logic        tx_underrun,
    input  wire logic        tx_final_start,
    input  wire logic        rx_char_valid,
    input  wire logic [7:0]  rx_char,
    input  wire logic        rx_char_is_ctrl,
    input  wire logic        rx_buf_avail,
    output logic             irq,
    output logic             rx_wr_valid,
    output logic [7:0]       rx_wr_data,
    output logic             rx_buf_close,
    output logic             rx_bcs_expected,
    output logic             bcs_accum_en,
    output logic             bcs_accum_reset
);

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    logic        wr_acc;
    logic        rd_acc;
    logic        addr_ok;
    logic [3:0]  cmd_code;
    assign wr_acc   = psel && penable && pwrite;
    assign rd_acc   = psel && penable && !pwrite;
    assign cmd_code = pwdata[3:0];
    assign addr_ok  = (paddr == ADDR_EVENT) || (paddr == ADDR_MASK)
                   || (paddr == ADDR_STATUS) || (paddr == ADDR_COMMAND)
                   || (paddr == ADDR_MODE) || (paddr == ADDR_DESC_BASE)
                   || (paddr == ADDR_DESC_PTR) || (paddr == ADDR_RX_INFO);

    logic cmd_wr;
    logic cmd_init;
    logic cmd_grace;
    logic cmd_hunt;
    logic cmd_rx_check_exclude;
    assign cmd_wr    = wr_acc && (paddr == ADDR_COMMAND);
    assign cmd_init  = cmd_wr && (cmd_code == CMD_INIT_PARAMS);
    assign cmd_grace = cmd_wr && (cmd_code == CMD_GRACEFUL);
    assign cmd_hunt  = cmd_wr && (cmd_code == CMD_HUNT);
    assign cmd_rx_check_exclude  = cmd_wr && (cmd_code == CMD_RESET_BCS);

    ////////////////////////////////////////////////////////////////////
    // Control registers
    logic [15:0] mask_reg;
    logic [15:0] mask_next;
    logic [2:0]  mode_reg;
    logic [2:0]  mode_next;
    logic [15:0] rx_base_reg;
    logic [15:0] rx_base_next;
    logic [15:0] tx_base_reg;
    logic [15:0] tx_base_next;
    logic [15:0] rx_ptr_reg;
    logic [15:0] rx_ptr_next;
    logic [15:0] tx_ptr_reg;
    logic [15:0] tx_ptr_next;
    logic        grace_pend_reg;
    logic        grace_pend_next;
    logic        cs_prev_reg;
    logic        grace_done;

    always_comb
    begin
        mask_next       = mask_reg;
        mode_next       = mode_reg;
        rx_base_next    = rx_base_reg;
        tx_base_next    = tx_base_reg;
        rx_ptr_next     = rx_ptr_reg;
        tx_ptr_next     = tx_ptr_reg;
        grace_pend_next = grace_pend_reg;
        grace_done      = 1'b0;
        if (wr_acc && paddr == ADDR_MASK)
        begin
            mask_next = pwdata[15:0];
        end
        if (wr_acc && paddr == ADDR_MODE)
        begin
            mode_next = pwdata[2:0];
        end
        if (wr_acc && paddr == ADDR_DESC_BASE)
        begin
            rx_base_next = pwdata[15:0];
            tx_base_next = pwdata[31:16];
        end
        if (cmd_init)
        begin
            rx_ptr_next = rx_base_reg;
            tx_ptr_next = tx_base_reg;
        end
        if (cmd_grace && !tx_msg_active)
        begin
            grace_done = 1'b1;
        end
        else if (cmd_grace)
        begin
            grace_pend_next = 1'b1;
        end
        if (grace_pend_reg && !tx_msg_active)
        begin
            grace_done      = 1'b1;
            grace_pend_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_reg       <= MASK_RESET;
            mode_reg       <= 3'h0;
            rx_base_reg    <= 16'h0000;
            tx_base_reg    <= 16'h0000;
            rx_ptr_reg     <= 16'h0000;
            tx_ptr_reg     <= 16'h0000;
            grace_pend_reg <= 1'b0;
            cs_prev_reg    <= 1'b0;
        end
        else
        begin
            mask_reg       <= mask_next;
            mode_reg       <= mode_next;
            rx_base_reg    <= rx_base_next;
            tx_base_reg    <= tx_base_next;
            rx_ptr_reg     <= rx_ptr_next;
            tx_ptr_reg     <= tx_ptr_next;
            grace_pend_reg <= grace_pend_next;
            cs_prev_reg    <= dpll_cs;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive control
    scem_rx_state_t rx_state_reg;
    scem_rx_state_t rx_state_next;
    logic [15:0]    rx_len_reg;
    logic [15:0]    rx_len_next;
    logic           wr_v_next;
    logic [7:0]     wr_d_next;
    logic           close_next;
    logic           bcs_exp_next;
    logic           acc_en_next;
    logic           acc_rst_next;
    logic           rch_set;
    logic           bsy_set;
    logic           is_ctrl;
    logic           transp;
    logic           take_char;
    assign transp = mode_reg[MODE_TRANSP];

    always_comb
    begin
        rx_state_next = rx_state_reg;
        rx_len_next   = rx_len_reg;
        wr_v_next     = 1'b0;
        wr_d_next     = rx_char;
        close_next    = 1'b0;
        bcs_exp_next  = rx_bcs_expected;
        acc_en_next   = 1'b0;
        acc_rst_next  = 1'b0;
        rch_set       = 1'b0;
        bsy_set       = 1'b0;
        is_ctrl       = 1'b0;
        take_char     = 1'b0;
        if (cmd_rx_check_exclude)
        begin
            acc_rst_next = 1'b1;
        end
        case (rx_state_reg)
            RX_HUNT:
            begin
                if (rx_char_valid && mode_reg[MODE_RX_EN] && rx_char != SYNC_CHAR)
                begin
                    rx_state_next = RX_DATA;
                    take_char     = 1'b1;
                end
            end
            RX_DATA:
            begin
                if (rx_char_valid && rx_char == SYNC_CHAR)
                begin
                    take_char = 1'b0;
                end
                else if (rx_char_valid && transp && rx_char == ESC_CHAR)
                begin
                    rx_state_next = RX_ESC;
                end
                else if (rx_char_valid)
                begin
                    take_char = 1'b1;
                    is_ctrl   = rx_char_is_ctrl && !transp;
                end
            end
            RX_ESC:
            begin
                if (rx_char_valid)
                begin
                    rx_state_next = RX_DATA;
                    take_char     = 1'b1;
                    is_ctrl       = rx_char_is_ctrl;
                end
            end
            RX_BUSY:
            begin
                rx_state_next = RX_BUSY;
            end
            default:
            begin
                rx_state_next = RX_HUNT;
            end
        endcase
        if (take_char && !rx_buf_avail)
        begin
            bsy_set       = 1'b1;
            rx_state_next = RX_BUSY;
        end
        else if (take_char)
        begin
            wr_v_next   = 1'b1;
            rch_set     = 1'b1;
            acc_en_next = !cmd_rx_check_exclude;
            rx_len_next = rx_len_reg + 16'h0001;
            if (is_ctrl)
            begin
                close_next    = 1'b1;
                bcs_exp_next  = (rx_char != ENQ_CHAR);
                rx_len_next   = 16'h0000;
                rx_state_next = RX_HUNT;
            end
            else if (rx_len_reg + 16'h0001 >= 16'(MAX_RX_LEN))
            begin
                close_next  = 1'b1;
                rx_len_next = 16'h0000;
            end
        end
        if (cmd_hunt)
        begin
            rx_state_next = RX_HUNT;
            rx_len_next   = 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state_reg    <= RX_HUNT;
            rx_len_reg      <= 16'h0000;
            rx_wr_valid     <= 1'b0;
            rx_wr_data      <= 8'h00;
            rx_buf_close    <= 1'b0;
            rx_bcs_expected <= 1'b0;
            bcs_accum_en    <= 1'b0;
            bcs_accum_reset <= 1'b0;
        end
        else
        begin
            rx_state_reg    <= rx_state_next;
            rx_len_reg      <= rx_len_next;
            rx_wr_valid     <= wr_v_next;
            rx_wr_data      <= wr_d_next;
            rx_buf_close    <= close_next;
            rx_bcs_expected <= bcs_exp_next;
            bcs_accum_en    <= acc_en_next;
            bcs_accum_reset <= acc_rst_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event flags
    logic [15:0] evt_set;
    logic [15:0] evt_clr;
    logic [15:0] event_flags_reg;
    always_comb
    begin
        evt_set          = 16'h0000;
        evt_set[EVT_DCC] = dpll_cs ^ cs_prev_reg;
        evt_set[EVT_GRA] = grace_done;
        evt_set[EVT_TXE] = tx_cts_lost || tx_underrun;
        evt_set[EVT_RCH] = rch_set;
        evt_set[EVT_BSY] = bsy_set;
        evt_set[EVT_TX]  = tx_final_start;
        evt_set[EVT_RX]  = close_next;
    end
    assign evt_clr = (wr_acc && paddr == ADDR_EVENT) ? pwdata[15:0] : 16'h0000;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_flag
            if (EVT_IMPL_MASK[gi])
            begin : g_impl
                scem_edge_flag u_flag (
                    .pclk    (pclk),
                    .presetn (presetn),
                    .set_evt (evt_set[gi]),
                    .clr_evt (evt_clr[gi]),
                    .flag    (event_flags_reg[gi])
                );
            end
            else
            begin : g_rsv
                assign event_flags_reg[gi] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Interrupt and bus answer
    logic [31:0] rdata_next;
    logic [7:0]  line_status_reg;
    always_comb
    begin
        line_status_reg                = STATUS_FIXED;
        line_status_reg[STATUS_CS_BIT] = dpll_cs;
        rdata_next                     = 32'h0000_0000;
        case (paddr)
            ADDR_EVENT:     rdata_next = {16'h0000, event_flags_reg};
            ADDR_MASK:      rdata_next = {16'h0000, mask_reg};
            ADDR_STATUS:    rdata_next = {24'h000000, line_status_reg};
            ADDR_MODE:      rdata_next = {29'h0, mode_reg};
            ADDR_DESC_BASE: rdata_next = {tx_base_reg, rx_base_reg};
            ADDR_DESC_PTR:  rdata_next = {tx_ptr_reg, rx_ptr_reg};
            ADDR_RX_INFO:   rdata_next = {14'h0, rx_state_reg, rx_len_reg};
            default:        rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end
        else
        begin
            prdata  <= (psel && !penable && !pwrite) ? rdata_next : prdata;
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            irq     <= |(event_flags_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    // 0x0013 enables bits 4, 1, 0
    chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == $past(|(event_flags_reg & mask_reg)))
        else $error("irq does not follow enabled flags");
    chk_clear_one: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == ADDR_EVENT && pwdata[EVT_RCH] && !rch_set)
        |=> !event_flags_reg[EVT_RCH])
        else $error("write one did not clear flag");
    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        rch_set |=> event_flags_reg[EVT_RCH])
        else $error("char flag not set");
    chk_dcc_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(dpll_cs) |=> ##1 event_flags_reg[EVT_DCC])
        else $error("carrier change missed");
    chk_grace_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_grace && !tx_msg_active) |=> event_flags_reg[EVT_GRA])
        else $error("graceful stop not immediate");
    chk_txe_set: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_cts_lost || tx_underrun) |=> event_flags_reg[EVT_TXE])
        else $error("tx error missed");
    chk_busy_discard: assert property (@(posedge pclk) disable iff (!presetn)
        bsy_set |=> !rx_wr_valid && event_flags_reg[EVT_BSY])
        else $error("busy char not discarded");
    chk_status_cs: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == ADDR_STATUS)
        |=> prdata[7:0] == {STATUS_FIXED[7:2], $past(dpll_cs), 1'b0})
        else $error("status layout wrong");
    cov_busy: cover property (@(posedge pclk) bsy_set);
    cov_close: cover property (@(posedge pclk) rx_buf_close);
    cov_irq: cover property (@(posedge pclk) $rose(irq));

endmodule

// [bench/scem_remote_station.sv]
/*
 * Remote synchronous station model: sends characters, moves carrier sense.
 * Assumes character strobes synchronous to pclk, one per call.
 */
module scem_remote_station
(
    input  wire logic pclk,
    output logic      rx_char_valid,
    output logic [7:0] rx_char,
    output logic      rx_char_is_ctrl,
    output logic      dpll_cs
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        rx_char_valid   = 1'b0;
        rx_char         = 8'hA5;
        rx_char_is_ctrl = 1'b0;
        dpll_cs         = 1'b0;
    end

    task automatic send(input logic [7:0] c, input logic k = 1'b0);
        @(posedge pclk);
        rx_char_valid   <= 1'b1;
        rx_char         <= c;
        rx_char_is_ctrl <= k;
        @(posedge pclk);
        rx_char_valid   <= 1'b0;
        rx_char_is_ctrl <= 1'b0;
        // Idle line never shows the stale character
        rx_char         <= ~c;
    endtask

    task automatic set_cs(input logic v);
        @(posedge pclk);
        dpll_cs <= v;
    endtask
endmodule

// [bench/testbench.sv]
/*
 * Self-checking bench for the event, mask and status block over APB.
 * Assumes zero-wait APB slave and the remote station model beside it.
 */
module testbench
    import scem_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, rx_char, rx_wr_data, last_wr;
    logic [31:0] pwdata, prdata;
    logic        dpll_cs, tx_msg_active, tx_cts_lost, tx_underrun, tx_final_start;
    logic        rx_char_valid, rx_char_is_ctrl, rx_buf_avail, rx_wr_valid, rx_buf_close;
    logic        rx_bcs_expected, bcs_accum_en, bcs_accum_reset;
    int          errors = 0;
    int          n_compared = 0;
    int          wr_cnt = 0;
    int          close_cnt = 0;
    int          acc_cnt = 0;
    int          rst_cnt = 0;

    scem_top #(.MAX_RX_LEN(16), .SYNC_CHAR(8'h33)) scem_top_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dpll_cs(dpll_cs), .tx_msg_active(tx_msg_active),
        .tx_cts_lost(tx_cts_lost), .tx_underrun(tx_underrun),
        .tx_final_start(tx_final_start), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .rx_char_is_ctrl(rx_char_is_ctrl),
        .rx_buf_avail(rx_buf_avail), .irq(irq), .rx_wr_valid(rx_wr_valid),
        .rx_wr_data(rx_wr_data), .rx_buf_close(rx_buf_close),
        .rx_bcs_expected(rx_bcs_expected), .bcs_accum_en(bcs_accum_en),
        .bcs_accum_reset(bcs_accum_reset));

    scem_remote_station scem_remote_station_inst (.pclk(pclk),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_char_is_ctrl(rx_char_is_ctrl), .dpll_cs(dpll_cs));

    always #5 pclk = ~pclk;

    always @(posedge pclk)
    begin
        if (rx_wr_valid === 1'b1)
        begin
            wr_cnt++;
            last_wr = rx_wr_data;
        end
        if (rx_buf_close === 1'b1)
            close_cnt++;
        if (bcs_accum_en === 1'b1)
            acc_cnt++;
        if (bcs_accum_reset === 1'b1)
            rst_cnt++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(what, q, exp);
    endtask

    task automatic pulse(input int which);
        @(posedge pclk);
        tx_underrun    <= (which == 0);
        tx_cts_lost    <= (which == 1);
        tx_final_start <= (which == 2);
        @(posedge pclk);
        {tx_underrun, tx_cts_lost, tx_final_start} <= 3'b000;
        repeat (3) @(posedge pclk);
    endtask

    task automatic test_reset();
        rd_chk("event", ADDR_EVENT, 32'h0000_0000);
        rd_chk("mask", ADDR_MASK, 32'h0000_0000);
        rd_chk("status", ADDR_STATUS, {24'h0, STATUS_FIXED});
        check("irq", {31'h0, irq}, 32'h0);
        $display("test_reset done");
    endtask

    task automatic test_regs();
        logic [31:0] q;
        logic        e;
        wr(ADDR_MASK, 32'hFFFF_FFFF);
        rd_chk("mask", ADDR_MASK, 32'h0000_FFFF);
        wr(ADDR_STATUS, 32'h0000_0000);
        rd_chk("status", ADDR_STATUS, {24'h0, STATUS_FIXED});
        apb(1'b1, 8'h40, 32'hFFFF_FFFF, q, e);
        check("slverr", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h40, 32'h0, q, e);
        check("unmapped", q, 32'h0);
        // Software clears stale events first
        // clear before enable
        wr(ADDR_EVENT, 32'h0000_FFFF);
        wr(ADDR_MASK, 32'h0000_0013);
        rd_chk("mask", ADDR_MASK, 32'h0000_0013);
        $display("test_regs done");
    endtask

    task automatic test_tx();
        pulse(0);
        rd_chk("event", ADDR_EVENT, 32'h1 << EVT_TXE);
        check("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_EVENT, 32'h0);
        pulse(2);
        rd_chk("event", ADDR_EVENT, (32'h1 << EVT_TXE) | (32'h1 << EVT_TX));
        wr(ADDR_EVENT, 32'h1 << EVT_TXE);
        rd_chk("event", ADDR_EVENT, 32'h1 << EVT_TX);
        check("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_EVENT, 32'h1 << EVT_TX);
        rd_chk("event", ADDR_EVENT, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        pulse(1);
        rd_chk("event", ADDR_EVENT, 32'h1 << EVT_TXE);
        wr(ADDR_EVENT, 32'h0000_FFFF);
        $display("test_tx done");
    endtask

    task automatic test_graceful();
        wr(ADDR_COMMAND, {28'h0, CMD_GRACEFUL});
        rd_chk("event", ADDR_EVENT, 32'h1 << EVT_GRA);
        wr(ADDR_EVENT, 32'h0000_FFFF);
        tx_msg_active <= 1'b1;
        wr(ADDR_COMMAND, {28'h0, CMD_GRACEFUL});
        rd_chk("event", ADDR_EVENT, 32'h0);
        tx_msg_active <= 1'b0;
        repeat (2) @(posedge pclk);
        rd_chk("event", ADDR_EVENT, 32'h1 << EVT_GRA);
        scem_remote_station_inst.set_cs(1'b1);
        repeat (3) @(posedge pclk);
        rd_chk("status", ADDR_STATUS, {24'h0, STATUS_FIXED | 8'(1 << STATUS_CS_BIT)});
        rd_chk("event", ADDR_EVENT, (32'h1 << EVT_GRA) | (32'h1 << EVT_DCC));
        scem_remote_station_inst.set_cs(1'b0);
        rd_chk("status", ADDR_STATUS, {24'h0, STATUS_FIXED});
        wr(ADDR_EVENT, 32'h0000_FFFF);
        $display("test_graceful done");
    endtask

    task automatic test_rx();
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_MODE, 32'h1 << MODE_RX_EN);
        rx_buf_avail <= 1'b1;
        scem_remote_station_inst.send(8'h33);
        scem_remote_station_inst.send(8'h41);
        scem_remote_station_inst.send(8'h33);
        repeat (3) @(posedge pclk);
        check("wr_cnt", wr_cnt, 1);
        check("wr_data", {24'h0, last_wr}, 32'h41);
        rd_chk("event", ADDR_EVENT, 32'h1 << EVT_RCH);
        for (int i = 1; i < 16; i++)
            scem_remote_station_inst.send(8'(i));
        repeat (3) @(posedge pclk);
        check("close_cnt", close_cnt, 1);
        rd_chk("event", ADDR_EVENT, (32'h1 << EVT_RCH) | (32'h1 << EVT_RX));
        wr(ADDR_EVENT, 32'h0000_FFFF);
        rx_buf_avail <= 1'b0;
        scem_remote_station_inst.send(8'h42);
        repeat (3) @(posedge pclk);
        rd_chk("event", ADDR_EVENT, 32'h1 << EVT_BSY);
        check("irq", {31'h0, irq}, 32'h0);
        rx_buf_avail <= 1'b1;
        scem_remote_station_inst.send(8'h43);
        repeat (3) @(posedge pclk);
        check("wr_cnt", wr_cnt, 16);
        wr(ADDR_COMMAND, {28'h0, CMD_HUNT});
        scem_remote_station_inst.send(8'h33);
        scem_remote_station_inst.send(8'h44);
        repeat (3) @(posedge pclk);
        check("wr_cnt", wr_cnt, 17);
        check("wr_data", {24'h0, last_wr}, 32'h44);
        $display("test_rx done");
    endtask

    task automatic test_block();
        wr(ADDR_DESC_BASE, 32'h0008_0010);
        wr(ADDR_COMMAND, {28'h0, CMD_INIT_PARAMS});
        rd_chk("ptr", ADDR_DESC_PTR, 32'h0008_0010);
        // character interrupt on at block start
        wr(ADDR_EVENT, 32'h0000_FFFF);
        wr(ADDR_MASK, 32'h0000_001B);
        scem_remote_station_inst.send(8'h01);
        repeat (3) @(posedge pclk);
        check("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_COMMAND, {28'h0, CMD_RESET_BCS});
        wr(ADDR_MASK, 32'h0000_0013);
        wr(ADDR_EVENT, 32'h0000_FFFF);
        check("bcs_rst", rst_cnt, 1);
        scem_remote_station_inst.send(8'h33);
        scem_remote_station_inst.send(8'h50);
        repeat (3) @(posedge pclk);
        check("irq", {31'h0, irq}, 32'h0);
        wr(ADDR_MODE, (32'h1 << MODE_RX_EN) | (32'h1 << MODE_TRANSP));
        scem_remote_station_inst.send(8'h03, 1'b1);
        scem_remote_station_inst.send(8'h55);
        scem_remote_station_inst.send(8'h2D, 1'b1);
        repeat (3) @(posedge pclk);
        check("last_wr", {24'h0, last_wr}, 32'h2D);
        check("close_cnt", close_cnt, 2);
        check("bcs_exp", {31'h0, rx_bcs_expected}, 32'h0);
        wr(ADDR_MODE, 32'h1 << MODE_RX_EN);
        scem_remote_station_inst.send(8'h02);
        scem_remote_station_inst.send(8'h03, 1'b1);
        repeat (3) @(posedge pclk);
        check("close_cnt", close_cnt, 3);
        check("bcs_exp", {31'h0, rx_bcs_expected}, 32'h1);
        check("acc_cnt", acc_cnt, 23);
        check("wr_cnt", wr_cnt, 23);
        $display("test_block done");
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #200000;
        errors++;
        end_of_test();
    end

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, tx_msg_active} = 6'b0;
        {tx_cts_lost, tx_underrun, tx_final_start, rx_buf_avail} = 4'b0;
        paddr  = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        test_regs();
        test_tx();
        test_graceful();
        test_rx();
        test_block();
        end_of_test();
    end
endmodule
